// file: irq_ctrl_defines.vh
// constants for the peripheral handshake and vectored interrupt controller
// assumes inclusion by bare name from each design file that needs them
`ifndef IRQ_CTRL_DEFINES_VH
`define IRQ_CTRL_DEFINES_VH

// register byte offsets on the axi4-lite slave
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_DEVADDR 8'h08

// ctrl field positions and reset value
`define CTRL_SRC_LO 0
`define CTRL_SRC_HI 1
`define CTRL_HI_REGION 2
`define CTRL_INIT 3
`define CTRL_RST 3'h0

// stimulus source codes held in ctrl
`define SRC_EXT 2'h0
`define SRC_OUT_EMPTY 2'h1
`define SRC_IN_FULL 2'h2

// status field positions
`define ST_OUT_EMPTY 0
`define ST_IN_FULL 1
`define ST_IRQ_ENABLE 2
`define ST_STIM_STORE 3
`define ST_PENDING 4
`define ST_ACTIVE 5
`define ST_VEC_DRIVE 6

// device address reset value, arbitrary
`define DEVADDR_RST 6'h0a

// select function codes; enable and disable codes are arbitrary
`define ENABLE_FUNC_CODE 3'h1
`define DISABLE_FUNC_CODE 3'h2
`define INIT_FUNC_CODE 3'h4

// sense function codes
`define SENSE_OUT_EMPTY 3'h0
`define SENSE_IN_FULL 3'h1

// vector layout
`define VEC_BASE_LO 4'h2
`define VEC_HI_REGION 16'h0100

// axi responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// file: pin_sync.v
// two-stage synchroniser with edge pulses for a group of pins
// assumes the pins are asynchronous to i_core_clk
`timescale 1ns/1ps
module pin_sync #(
    parameter W = 1,
    parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
    input wire i_core_clk, // controller clock
    input wire i_resetn, // synchronous reset, active low
    input wire [W-1:0] i_async, // raw pin levels
    output wire [W-1:0] o_level, // synchronised level
    output wire [W-1:0] o_rise, // one-cycle rising pulse
    output wire [W-1:0] o_fall // one-cycle falling pulse
);
    reg [W-1:0] meta_r; // first stage, read only by stage two
    reg [W-1:0] sync_r; // second stage
    reg [W-1:0] prev_r; // delayed copy for edges

    // stage chain; edges look only at stage two and later
    always @(posedge i_core_clk) begin
        if (!i_resetn) begin
            meta_r <= RST_VAL;
            sync_r <= RST_VAL;
            prev_r <= RST_VAL;
        end else begin
            meta_r <= i_async;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    assign o_level = sync_r;
    assign o_rise = sync_r & ~prev_r;
    assign o_fall = ~sync_r & prev_r;
endmodule // pin_sync

// file: vector_gen.v
// interrupt address generator: base plus strap offset plus region shift
// assumes offset selects are already synchronised, active low
`timescale 1ns/1ps
`include "irq_ctrl_defines.vh"
module vector_gen #(
    parameter SEL_W = 7
) (
    input wire [SEL_W-1:0] i_vector_offset_sel_n, // weights 4..256, grounded adds
    input wire i_hi_region, // shift into second 256-word region
    output wire [15:0] o_vector // even vector address
);
    wire [15:0] offset; // summed grounded weights
    wire [15:0] base; // low nibble base
    wire [15:0] sum; // raw total

    // each select sits at its binary weight, so the sum is a shift
    assign offset = {{(14 - SEL_W){1'b0}}, ~i_vector_offset_sel_n, 2'b00};
    assign base = {12'h000, `VEC_BASE_LO};
    assign sum = base + offset + (i_hi_region ? `VEC_HI_REGION : 16'h0000);
    // bit 0 forced low keeps the vector even whatever the straps do
    assign o_vector = {sum[15:1], 1'b0};
endmodule // vector_gen

// file: periph_irq_ctrl.v
// peripheral interface controller: buffer handshake flags and one vectored interrupt
// assumes io bus pins are asynchronous and synchronised here; axi4-lite on i_core_clk
`timescale 1ns/1ps
`include "irq_ctrl_defines.vh"
module periph_irq_ctrl #(
    parameter ADDR_W = 6,
    parameter SEL_W = 7
) (
    input wire i_core_clk, // controller clock, 40 MHz
    input wire i_resetn, // synchronous reset, active low
    // io bus from the processor
    input wire [ADDR_W-1:0] i_io_addr, // device address lines
    input wire [2:0] i_io_func, // function code lines
    input wire i_select_strobe, // select command strobe
    input wire i_in_strobe, // input command strobe
    input wire i_out_strobe, // output command strobe
    input wire i_sense_strobe, // sense command strobe
    input wire i_cmd_pulse, // command pulse
    input wire i_proc_io_clock, // processor io clock
    input wire i_vector_request, // interrupt address request
    input wire i_prio_in_n, // priority in, active low
    input wire i_sys_rst_n, // processor system reset, active low
    input wire [SEL_W-1:0] i_vector_offset_sel_n, // vector offset straps, active low
    output wire o_shared_irq_n, // shared interrupt request, active low
    output wire o_prio_out_n, // priority out, active low
    output wire [15:0] o_data_out, // data bus drive value
    output wire o_data_oe_n, // data bus enable, low while driving
    output wire o_sense_resp_n, // sense response, active low
    // peripheral side
    input wire i_word_sent, // output word transmitted
    input wire i_word_received, // input word placed in buffer
    input wire i_ext_stimulus, // external interrupt stimulus
    input wire i_stimulus_polarity, // active level of stimulus
    output wire o_out_empty, // output buffer empty flag
    output wire o_in_full, // input buffer full flag
    // axi4-lite slave
    input wire [7:0] i_s_axi_awaddr, // write address
    input wire i_s_axi_awvalid, // write address valid
    output wire o_s_axi_awready, // write address ready
    input wire [31:0] i_s_axi_wdata, // write data
    input wire [3:0] i_s_axi_wstrb, // write byte strobes
    input wire i_s_axi_wvalid, // write data valid
    output wire o_s_axi_wready, // write data ready
    output wire [1:0] o_s_axi_bresp, // write response
    output wire o_s_axi_bvalid, // write response valid
    input wire i_s_axi_bready, // write response ready
    input wire [7:0] i_s_axi_araddr, // read address
    input wire i_s_axi_arvalid, // read address valid
    output wire o_s_axi_arready, // read address ready
    output wire [31:0] o_s_axi_rdata, // read data
    output wire [1:0] o_s_axi_rresp, // read response
    output wire o_s_axi_rvalid, // read data valid
    input wire i_s_axi_rready // read data ready
);
    // synchronised pin group bit positions
    localparam P_SEL = 0;
    localparam P_IN = 1;
    localparam P_OUT = 2;
    localparam P_SENSE = 3;
    localparam P_PULSE = 4;
    localparam P_IOCLK = 5;
    localparam P_VREQ = 6;
    localparam P_PRIO_N = 7;
    localparam P_RST_N = 8;
    localparam P_SENT = 9;
    localparam P_RCVD = 10;
    localparam P_STIM = 11;
    localparam P_POL = 12;
    localparam NCTL = 13;
    localparam NBUS = ADDR_W + 3 + SEL_W;

    wire [NCTL-1:0] ctl_lvl; // synced control levels
    wire [NCTL-1:0] ctl_rise; // rising pulses
    wire [NCTL-1:0] ctl_fall; // falling pulses
    wire [NBUS-1:0] bus_lvl; // synced address, function, straps

    // control pins through two flops; active-low pins and io clock idle high
    pin_sync #(
        .W(NCTL),
        .RST_VAL(13'h11a0)
    ) u_ctl_sync (
        .i_core_clk(i_core_clk),
        .i_resetn(i_resetn),
        .i_async({i_stimulus_polarity, i_ext_stimulus, i_word_received, i_word_sent, i_sys_rst_n,
                  i_prio_in_n, i_vector_request, i_proc_io_clock, i_cmd_pulse, i_sense_strobe,
                  i_out_strobe, i_in_strobe, i_select_strobe}),
        .o_level(ctl_lvl),
        .o_rise(ctl_rise),
        .o_fall(ctl_fall)
    );

    // bus lines through two flops; straps idle high (no offset)
    pin_sync #(
        .W(NBUS),
        .RST_VAL({{SEL_W{1'b1}}, {(ADDR_W + 3){1'b0}}})
    ) u_bus_sync (
        .i_core_clk(i_core_clk),
        .i_resetn(i_resetn),
        .i_async({i_vector_offset_sel_n, i_io_func, i_io_addr}),
        .o_level(bus_lvl),
        .o_rise(),
        .o_fall()
    );

    wire [ADDR_W-1:0] io_addr_s = bus_lvl[ADDR_W-1:0]; // synced address
    wire [2:0] io_func_s = bus_lvl[ADDR_W+2:ADDR_W]; // synced function
    wire [SEL_W-1:0] offset_sel_n_s = bus_lvl[NBUS-1:ADDR_W+3]; // synced straps

    // software-visible registers
    reg [2:0] ctrl_r; // stimulus source and region select
    reg [ADDR_W-1:0] devaddr_r; // assigned device address
    reg soft_init_r; // one-cycle software initialize

    // handshake and interrupt state
    reg out_empty_flag_r; // output buffer empty
    reg in_full_flag_r; // input buffer full
    reg irq_enable_ff_r; // interrupt enable
    reg stimulus_store_ff_r; // captured stimulus
    reg pending_ff_r; // interrupt pending
    reg stim_act_d_r; // previous active stimulus level
    reg shared_irq_n_r; // registered irq line
    reg prio_out_n_r; // registered priority out
    reg [15:0] data_out_r; // registered vector drive
    reg data_oe_n_r; // registered bus enable
    reg sense_resp_n_r; // registered sense answer

    // command decode; every addressed command needs the match
    wire addr_match = (io_addr_s == devaddr_r);
    wire pulse_rise = ctl_rise[P_PULSE]; // command pulse event
    wire select_strobe = addr_match & ctl_lvl[P_SEL] & pulse_rise;
    wire out_write = addr_match & ctl_lvl[P_OUT] & pulse_rise;
    wire in_read = addr_match & ctl_lvl[P_IN] & pulse_rise;

    // init from select code 4, system reset low, or software
    wire init_pulse = select_strobe & (io_func_s == `INIT_FUNC_CODE);
    wire ctrl_init = init_pulse | ~ctl_lvl[P_RST_N] | soft_init_r;

    wire enable_func_code = select_strobe & (io_func_s == `ENABLE_FUNC_CODE);
    wire disable_func_code = select_strobe & (io_func_s == `DISABLE_FUNC_CODE);

    // stimulus source: external pin or either buffer flag
    reg stim_src_lvl; // chosen stimulus level
    always @* begin
        case (ctrl_r[`CTRL_SRC_HI:`CTRL_SRC_LO])
            `SRC_OUT_EMPTY: stim_src_lvl = out_empty_flag_r;
            `SRC_IN_FULL: stim_src_lvl = in_full_flag_r;
            default: stim_src_lvl = ctl_lvl[P_STIM]; // external pin
        endcase
    end

    // active when level equals the polarity selector; flags are active high
    wire stim_pol = (ctrl_r[`CTRL_SRC_HI:`CTRL_SRC_LO] == `SRC_EXT) ? ctl_lvl[P_POL] : 1'b1;
    wire stim_active = ~(stim_src_lvl ^ stim_pol);
    wire stim_rise = stim_active & ~stim_act_d_r;

    // priority and vector gating
    wire prio_in = ~ctl_lvl[P_PRIO_N]; // priority granted from upstream
    wire active_request = pending_ff_r & prio_in;
    // processor loads the vector before pulsing, so pulse means taken
    wire vector_drive = ctl_lvl[P_VREQ] & active_request;
    wire [15:0] vector; // generated interrupt address

    vector_gen #(
        .SEL_W(SEL_W)
    ) u_vec (
        .i_vector_offset_sel_n(offset_sel_n_s),
        .i_hi_region(ctrl_r[`CTRL_HI_REGION]),
        .o_vector(vector)
    );

    // output-empty flag; set beats clear so a late word_sent is kept
    always @(posedge i_core_clk) begin
        if (!i_resetn) begin
            out_empty_flag_r <= 1'b1;
        end else if (ctrl_init | ctl_rise[P_SENT]) begin
            out_empty_flag_r <= 1'b1;
        end else if (out_write) begin
            out_empty_flag_r <= 1'b0;
        end
    end

    // input-full flag; init dominates, then set beats read clear
    always @(posedge i_core_clk) begin
        if (!i_resetn) begin
            in_full_flag_r <= 1'b0;
        end else if (ctrl_init) begin
            in_full_flag_r <= 1'b0;
        end else if (ctl_rise[P_RCVD]) begin
            in_full_flag_r <= 1'b1;
        end else if (in_read) begin
            in_full_flag_r <= 1'b0;
        end
    end

    // interrupt enable: set by enable code, cleared by disable or init
    always @(posedge i_core_clk) begin
        if (!i_resetn) begin
            irq_enable_ff_r <= 1'b0;
        end else if (ctrl_init | disable_func_code) begin
            irq_enable_ff_r <= 1'b0;
        end else if (enable_func_code) begin
            irq_enable_ff_r <= 1'b1;
        end
    end

    // stimulus store: new edge beats the acknowledge clear, init wins
    always @(posedge i_core_clk) begin
        if (!i_resetn) begin
            stimulus_store_ff_r <= 1'b0;
            stim_act_d_r <= 1'b0;
        end else begin
            stim_act_d_r <= stim_active;
            if (ctrl_init) begin
                stimulus_store_ff_r <= 1'b0;
            end else if (irq_enable_ff_r & stim_rise) begin
                stimulus_store_ff_r <= 1'b1;
            end else if (vector_drive & pulse_rise) begin
                stimulus_store_ff_r <= 1'b0;
            end
        end
    end

    // pending follows enable and store at each io clock fall only;
    // io clock stopped by the processor holds the request steady
    always @(posedge i_core_clk) begin
        if (!i_resetn) begin
            pending_ff_r <= 1'b0;
        end else if (ctl_fall[P_IOCLK]) begin
            pending_ff_r <= irq_enable_ff_r & stimulus_store_ff_r;
        end
    end

    // io bus outputs, all registered
    always @(posedge i_core_clk) begin
        if (!i_resetn) begin
            shared_irq_n_r <= 1'b1;
            prio_out_n_r <= 1'b1;
            data_out_r <= 16'h0000;
            data_oe_n_r <= 1'b1;
            sense_resp_n_r <= 1'b1;
        end else begin
            shared_irq_n_r <= ~active_request;
            // pass priority only while not pending ourselves
            prio_out_n_r <= ~(prio_in & ~pending_ff_r);
            data_out_r <= vector_drive ? vector : 16'h0000;
            data_oe_n_r <= ~vector_drive;
            // sense answers while the addressed sense strobe is up
            if (addr_match & ctl_lvl[P_SENSE]) begin
                case (io_func_s)
                    `SENSE_OUT_EMPTY: sense_resp_n_r <= ~out_empty_flag_r;
                    `SENSE_IN_FULL: sense_resp_n_r <= ~in_full_flag_r;
                    default: sense_resp_n_r <= 1'b1; // no condition
                endcase
            end else begin
                sense_resp_n_r <= 1'b1;
            end
        end
    end

    // axi4-lite write channel state
    reg awready_r; // address ready
    reg wready_r; // data ready
    reg aw_have_r; // address held
    reg w_have_r; // data held
    reg [7:0] waddr_r; // held write address
    reg [31:0] wdata_r; // held write data
    reg wstrb0_r; // held byte 0 strobe
    reg bvalid_r; // response valid
    reg [1:0] bresp_r; // response code

    wire wr_fire = aw_have_r & w_have_r & ~bvalid_r; // commit cycle

    // address and data taken in either order, response after both
    always @(posedge i_core_clk) begin
        if (!i_resetn) begin
            awready_r <= 1'b1;
            wready_r <= 1'b1;
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            waddr_r <= 8'h00;
            wdata_r <= 32'h00000000;
            wstrb0_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= `RESP_OKAY;
        end else begin
            if (i_s_axi_awvalid & awready_r) begin
                waddr_r <= i_s_axi_awaddr;
                aw_have_r <= 1'b1;
                awready_r <= 1'b0;
            end
            if (i_s_axi_wvalid & wready_r) begin
                wdata_r <= i_s_axi_wdata;
                wstrb0_r <= i_s_axi_wstrb[0];
                w_have_r <= 1'b1;
                wready_r <= 1'b0;
            end
            if (wr_fire) begin
                aw_have_r <= 1'b0;
                w_have_r <= 1'b0;
                bvalid_r <= 1'b1;
                // status is read-only but mapped; only holes are errors
                if (waddr_r == `REG_CTRL || waddr_r == `REG_STATUS || waddr_r == `REG_DEVADDR) begin
                    bresp_r <= `RESP_OKAY;
                end else begin
                    bresp_r <= `RESP_SLVERR;
                end
            end
            if (bvalid_r & i_s_axi_bready) begin
                bvalid_r <= 1'b0;
                awready_r <= 1'b1;
                wready_r <= 1'b1;
            end
        end
    end

    // writable registers; all fields live in byte 0
    always @(posedge i_core_clk) begin
        if (!i_resetn) begin
            ctrl_r <= `CTRL_RST;
            devaddr_r <= `DEVADDR_RST;
            soft_init_r <= 1'b0;
        end else begin
            soft_init_r <= 1'b0;
            if (wr_fire & wstrb0_r & (waddr_r == `REG_CTRL)) begin
                ctrl_r <= wdata_r[2:0];
                soft_init_r <= wdata_r[`CTRL_INIT];
            end
            if (wr_fire & wstrb0_r & (waddr_r == `REG_DEVADDR)) begin
                devaddr_r <= wdata_r[ADDR_W-1:0];
            end
        end
    end

    // axi4-lite read channel
    reg arready_r; // read address ready
    reg rvalid_r; // read data valid
    reg [31:0] rdata_r; // read data
    reg [1:0] rresp_r; // read response

    wire [31:0] status_word = {25'h0000000, vector_drive, active_request, pending_ff_r,
                               stimulus_store_ff_r, irq_enable_ff_r, in_full_flag_r, out_empty_flag_r};

    // one read in flight; data captured at the address handshake
    always @(posedge i_core_clk) begin
        if (!i_resetn) begin
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h00000000;
            rresp_r <= `RESP_OKAY;
        end else if (i_s_axi_arvalid & arready_r) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b1;
            rresp_r <= `RESP_OKAY;
            case (i_s_axi_araddr)
                `REG_CTRL: rdata_r <= {29'h00000000, ctrl_r}; // init bit reads zero
                `REG_STATUS: rdata_r <= status_word;
                `REG_DEVADDR: rdata_r <= {{(32 - ADDR_W){1'b0}}, devaddr_r};
                default: begin
                    rdata_r <= 32'h00000000;
                    rresp_r <= `RESP_SLVERR; // unmapped
                end
            endcase
        end else if (rvalid_r & i_s_axi_rready) begin
            rvalid_r <= 1'b0;
            arready_r <= 1'b1;
        end
    end

    assign o_shared_irq_n = shared_irq_n_r;
    assign o_prio_out_n = prio_out_n_r;
    assign o_data_out = data_out_r;
    assign o_data_oe_n = data_oe_n_r;
    assign o_sense_resp_n = sense_resp_n_r;
    assign o_out_empty = out_empty_flag_r;
    assign o_in_full = in_full_flag_r;
    assign o_s_axi_awready = awready_r;
    assign o_s_axi_wready = wready_r;
    assign o_s_axi_bresp = bresp_r;
    assign o_s_axi_bvalid = bvalid_r;
    assign o_s_axi_arready = arready_r;
    assign o_s_axi_rdata = rdata_r;
    assign o_s_axi_rresp = rresp_r;
    assign o_s_axi_rvalid = rvalid_r;
endmodule // periph_irq_ctrl

// file: irq_ctrl_monitor.sv
// checker on the controller flags, priority chain and vector drive
// assumes a bind onto periph_irq_ctrl; it sees top ports only
`timescale 1ns/1ps
module irq_ctrl_monitor (
    input wire i_core_clk, // clock
    input wire i_resetn, // reset
    input wire i_sys_rst_n, // system reset pin
    input wire i_word_sent, // word sent
    input wire i_word_received, // word in
    input wire o_shared_irq_n, // irq line
    input wire o_prio_out_n, // priority out
    input wire [15:0] o_data_out, // vector
    input wire o_data_oe_n, // drive enable
    input wire o_out_empty, // empty flag
    input wire o_in_full // full flag
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_resetn);
    // end of a vector drive
    sequence drive_end_s;
        !o_data_oe_n ##1 o_data_oe_n;
    endsequence
    init_state_a: assert property (disable iff (1'b0)
        !i_resetn |=> o_out_empty && !o_in_full) else $error("bad reset state");
    sent_set_a: assert property ($rose(i_word_sent) && i_sys_rst_n |-> ##[1:6] o_out_empty)
        else $error("empty not set");
    recv_set_a: assert property ($rose(i_word_received) && i_sys_rst_n |-> ##[1:6] o_in_full)
        else $error("full not set");
    sys_init_a: assert property (!i_sys_rst_n [*5] |-> o_out_empty && !o_in_full)
        else $error("no system init");
    vec_form_a: assert property (!o_data_oe_n |-> o_data_out[1:0] == 2'h2 && o_data_out[15:10] == 6'h00)
        else $error("vector out of range");
    drive_irq_a: assert property (!o_data_oe_n |-> !o_shared_irq_n)
        else $error("drive without request");
    irq_block_a: assert property (!o_shared_irq_n |-> o_prio_out_n)
        else $error("priority passed on");
    drive_end_a: assert property (drive_end_s |-> o_data_out == 16'h0000)
        else $error("bus not released");
endmodule // irq_ctrl_monitor

bind periph_irq_ctrl irq_ctrl_monitor irq_ctrl_monitor_i (.*);

// file: proc_model.sv
// processor model: io bus commands, io clock and vector acknowledge
// assumes its tasks are called just after a rising core clock edge
`timescale 1ns/1ps
module proc_model (
    input wire i_clk, // core clock
    input wire [15:0] i_data_out, // data bus
    input wire i_sense_resp_n, // sense answer
    output logic [5:0] o_io_addr, // device address
    output logic [2:0] o_io_func, // function code
    output logic [3:0] o_cmd_kind, // select, in, out, sense
    output logic o_cmd_pulse, // command pulse
    output logic o_io_clock, // io clock, rests high
    output logic o_vreq // vector request
);
    // idle bus; released lines show a non-matching pattern
    initial begin
        {o_io_addr, o_io_func, o_cmd_kind, o_cmd_pulse, o_io_clock, o_vreq} = {9'h1ff, 4'h0, 3'h2};
    end
    // lines settle well before the pulse so the synchroniser sees them stable
    task automatic io_cmd(input [3:0] k, input [5:0] a, input [2:0] f, output s);
        {o_io_addr, o_io_func, o_cmd_kind} <= {a, f, k};
        repeat (4) @(posedge i_clk);
        o_cmd_pulse <= 1'b1;
        repeat (4) @(posedge i_clk);
        s = i_sense_resp_n;
        {o_io_addr, o_io_func, o_cmd_kind, o_cmd_pulse} <= {~a, ~f, 5'h00};
        repeat (4) @(posedge i_clk);
    endtask
    // io clock run: falls, then rises again
    task automatic io_fall();
        o_io_clock <= 1'b0;
        repeat (4) @(posedge i_clk);
        o_io_clock <= 1'b1;
        repeat (4) @(posedge i_clk);
    endtask
    // take the vector first, pulse only afterwards
    task automatic vec_ack(output [15:0] v);
        o_vreq <= 1'b1;
        repeat (5) @(posedge i_clk);
        v = i_data_out;
        o_cmd_pulse <= 1'b1;
        repeat (5) @(posedge i_clk);
        {o_cmd_pulse, o_vreq} <= 2'h0;
        repeat (4) @(posedge i_clk);
    endtask
endmodule // proc_model

// file: tb.sv
// bench for the handshake flags and vectored interrupt controller
// assumes proc_model stands in for the processor on the io bus
`timescale 1ns/1ps
`include "irq_ctrl_defines.vh"
module tb;
    logic i_core_clk = 1'b0, i_resetn = 1'b0, i_prio_in_n = 1'b0, i_sys_rst_n = 1'b1, i_word_sent = 1'b0;
    logic i_word_received = 1'b0, i_ext_stimulus = 1'b0, i_stimulus_polarity = 1'b1, sn;
    logic i_s_axi_awvalid = 1'b0, i_s_axi_wvalid = 1'b0, i_s_axi_bready = 1'b0;
    logic i_s_axi_arvalid = 1'b0, i_s_axi_rready = 1'b0;
    logic [6:0] i_vector_offset_sel_n = 7'h7f;
    logic [7:0] i_s_axi_awaddr = 8'h00, i_s_axi_araddr = 8'h00;
    logic [31:0] i_s_axi_wdata = 32'h0, rd;
    logic [3:0] i_s_axi_wstrb = 4'hf;
    logic [1:0] rr;
    logic [15:0] vec;
    wire [5:0] i_io_addr;
    wire [2:0] i_io_func;
    wire i_select_strobe, i_in_strobe, i_out_strobe, i_sense_strobe, i_cmd_pulse, i_proc_io_clock, i_vector_request;
    wire o_shared_irq_n, o_prio_out_n, o_data_oe_n, o_sense_resp_n, o_out_empty, o_in_full;
    wire o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid;
    wire [15:0] o_data_out;
    wire [1:0] o_s_axi_bresp, o_s_axi_rresp;
    wire [31:0] o_s_axi_rdata;
    int mismatches = 0, tests_run = 0, cycles = 0;
    periph_irq_ctrl periph_irq_ctrl_i (.*);
    proc_model proc_model_i (.i_clk(i_core_clk), .i_data_out(o_data_out), .i_sense_resp_n(o_sense_resp_n),
        .o_io_addr(i_io_addr), .o_io_func(i_io_func), .o_cmd_pulse(i_cmd_pulse), .o_io_clock(i_proc_io_clock),
        .o_cmd_kind({i_select_strobe, i_in_strobe, i_out_strobe, i_sense_strobe}), .o_vreq(i_vector_request));
    // 40 mhz core clock
    initial begin
        forever #12.5 i_core_clk = ~i_core_clk;
    end
    // hang guard, far above the run's length
    always @(posedge i_core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            mismatches++;
            results();
        end
    end
    task automatic results();
        $display("compares %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge i_core_clk);
    endtask
    // write: each channel dropped on its own handshake
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        bit aw = 1'b1, w = 1'b1, b = 1'b1;
        @(posedge i_core_clk);
        {i_s_axi_awaddr, i_s_axi_wdata, i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready} <= {a, d, 3'h7};
        while (aw || w || b) begin
            @(posedge i_core_clk);
            if (b && o_s_axi_bvalid === 1'b1) rr = o_s_axi_bresp;
            b = b && o_s_axi_bvalid !== 1'b1;
            {aw, w} = {aw && o_s_axi_awready !== 1'b1, w && o_s_axi_wready !== 1'b1};
            {i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready} <= {aw, w, b};
        end
    endtask
    task automatic axi_rd(input logic [7:0] a);
        bit ar = 1'b1, r = 1'b1;
        @(posedge i_core_clk);
        {i_s_axi_araddr, i_s_axi_arvalid, i_s_axi_rready} <= {a, 2'h3};
        while (ar || r) begin
            @(posedge i_core_clk);
            if (r && o_s_axi_rvalid === 1'b1) {rd, rr} = {o_s_axi_rdata, o_s_axi_rresp};
            {ar, r} = {ar && o_s_axi_arready !== 1'b1, r && o_s_axi_rvalid !== 1'b1};
            {i_s_axi_arvalid, i_s_axi_rready} <= {ar, r};
        end
    endtask
    task automatic st(input logic [31:0] exp);
        axi_rd(`REG_STATUS);
        chk(rd, exp);
    endtask
    task automatic cmd(input logic [3:0] k, input logic [2:0] f);
        proc_model_i.io_cmd(k, 6'h0a, f, sn);
    endtask
    // main sequence: flags, then the interrupt cycle, then disable and init
    initial begin
        tick(20);
        i_resetn <= 1'b1;
        st(32'h01);
        axi_wr(8'h0c, 32'h7);
        chk(rr, `RESP_SLVERR);
        axi_rd(8'h0c);
        chk(rr, `RESP_SLVERR);
        proc_model_i.io_cmd(4'h2, 6'h0b, 3'h0, sn);
        chk(o_out_empty, 1'b1);
        cmd(4'h2, 3'h0);
        chk(o_out_empty, 1'b0);
        cmd(4'h1, `SENSE_OUT_EMPTY);
        chk(sn, 1'b1);
        i_word_sent <= 1'b1;
        tick(6);
        chk(o_out_empty, 1'b1);
        cmd(4'h1, `SENSE_OUT_EMPTY);
        chk(sn, 1'b0);
        {i_word_sent, i_word_received} <= 2'h1;
        tick(6);
        chk(o_in_full, 1'b1);
        cmd(4'h1, `SENSE_IN_FULL);
        chk(sn, 1'b0);
        cmd(4'h4, 3'h0);
        chk(o_in_full, 1'b0);
        {i_word_received, i_vector_offset_sel_n} <= {1'b0, 7'h77};
        axi_wr(`REG_CTRL, 32'h4);
        chk(rr, `RESP_OKAY);
        cmd(4'h8, `ENABLE_FUNC_CODE);
        i_ext_stimulus <= 1'b1;
        tick(6);
        st(32'h0d);
        proc_model_i.io_fall();
        st(32'h3d);
        chk({o_shared_irq_n, o_prio_out_n}, 2'h1);
        proc_model_i.vec_ack(vec);
        chk(vec, 16'h0122);
        st(32'h35);
        i_ext_stimulus <= 1'b0;
        proc_model_i.io_fall();
        st(32'h05);
        cmd(4'h8, `DISABLE_FUNC_CODE);
        i_ext_stimulus <= 1'b1;
        tick(6);
        st(32'h01);
        i_stimulus_polarity <= 1'b0;
        cmd(4'h8, `ENABLE_FUNC_CODE);
        i_ext_stimulus <= 1'b0;
        tick(6);
        st(32'h0d);
        axi_wr(`REG_CTRL, 32'hc);
        st(32'h01);
        cmd(4'h8, `ENABLE_FUNC_CODE);
        cmd(4'h8, `INIT_FUNC_CODE);
        st(32'h01);
        axi_wr(`REG_CTRL, 32'h2);
        cmd(4'h8, `ENABLE_FUNC_CODE);
        i_word_received <= 1'b1;
        tick(6);
        st(32'h0f);
        i_sys_rst_n <= 1'b0;
        tick(8);
        st(32'h01);
        results();
    end
endmodule // tb
